/* cmiop_pkg.sv */
package cmiop_pkg;
  localparam int          NPORTS        = 7;
  localparam int          PW            = 8;
  localparam int          AW            = 8;
  localparam int          DBW           = 16;
  // port indices
  localparam logic [2:0]  PORT_A        = 3'h0;
  localparam logic [2:0]  PORT_B        = 3'h1;
  localparam logic [2:0]  PORT_C        = 3'h2;
  localparam logic [2:0]  PORT_D        = 3'h3;
  localparam logic [2:0]  PORT_E        = 3'h4;
  localparam logic [2:0]  PORT_F        = 3'h5;
  localparam logic [2:0]  PORT_G        = 3'h6;
  // register address: addr[5:3] selects port, addr[2:0] selects register
  localparam int          PORT_SEL_LSB  = 3;
  localparam int          REG_SEL_W     = 3;
  localparam logic [2:0]  REG_DATA_IN   = 3'h0;
  localparam logic [2:0]  REG_DATA_OUT  = 3'h1;
  localparam logic [2:0]  REG_DIRECTION = 3'h2;
  localparam logic [2:0]  REG_DRIVE     = 3'h3;
  localparam logic [2:0]  REG_MODE      = 3'h4;
  localparam logic [7:0]  ADDR_VM       = 8'h38;
  localparam logic [7:0]  ADDR_WIN_MASK = 8'hc0;
  localparam int          VM_PERIPH_BIT = 7;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  FULL_MASK     = 8'hff;
  localparam logic [7:0]  NIBBLE_MASK   = 8'h0f;
  localparam logic [7:0]  ZERO_MASK     = 8'h00;
  // which ports carry each register
  localparam logic [6:0]  HAS_MODE      = 7'h70;
  localparam logic [6:0]  HAS_DRIVE     = 7'h5b;
  localparam logic [6:0]  HAS_OE_TERM   = 7'h27;
  localparam int          JTAG_PINS     = 4;
  localparam int          DB_HI_LSB     = 8;
endpackage : cmiop_pkg

/* cmiop_cfg_if.sv */
interface cmiop_cfg_if;
  logic [7:0] mode;     // address-out select per pin
  logic [7:0] dir;      // direction bits
  logic [7:0] drive;    // open-drain select
  logic [7:0] dout;     // stored output data
  logic [7:0] addr;     // latched address bits for this port
  logic [7:0] oe_term;  // logic-array output enable term
  logic [7:0] mask;     // implemented pins
  logic [7:0] ovr_en;   // per-pin takeover by a special function
  logic [7:0] ovr_val;
  logic [7:0] ovr_oe;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  modport ctrl  (output mode, dir, drive, dout, addr, oe_term, mask, ovr_en, ovr_val, ovr_oe,
                 input pin_o, pin_oe);
  modport slice (input mode, dir, drive, dout, addr, oe_term, mask, ovr_en, ovr_val, ovr_oe,
                 output pin_o, pin_oe);
endinterface : cmiop_cfg_if

/* cmiop_pin_slice.sv */
module cmiop_pin_slice
(
  cmiop_cfg_if.slice cfg  // one port's configuration and pad drive
);
  import cmiop_pkg::*;

  always_comb
  begin
    for (int i = 0; i < PW; i++)
    begin
      logic val;
      logic en;
      val = 1'b0;
      en  = 1'b0;
      if (cfg.ovr_en[i])
      begin
        // special functions drive push-pull and bypass the per-pin config
        cfg.pin_o[i]  = cfg.ovr_val[i];
        cfg.pin_oe[i] = cfg.ovr_oe[i] & cfg.mask[i];
      end
      else
      begin
        en  = cfg.dir[i] | cfg.oe_term[i];
        val = cfg.mode[i] ? cfg.addr[i] : cfg.dout[i];
        if (cfg.drive[i])
        begin
          // open drain: only the low level is driven, an external pull-up makes high
          cfg.pin_o[i]  = 1'b0;
          cfg.pin_oe[i] = en & ~val & cfg.mask[i];
        end
        else
        begin
          cfg.pin_o[i]  = val;
          cfg.pin_oe[i] = en & cfg.mask[i];
        end
      end
    end
  end
endmodule : cmiop_pin_slice

/* cmiop_port.sv */
// Functional notes
// - data port mode hands upper ports to bus
// - mapping register bit 7 enables peripheral buffer
// - buffer floats unless a peripheral select active
// - jtag takes its pins only during programming
// - drive strap pattern in reset, bus idle
// - after reset strap stops, data port resumes
// - each register bit controls its own pin
// - configuration registers reset to zero
// - mode bit zero io, one address out
// - direction one output, zero input
// - direction or enable term makes output
// - four-pin port has four direction bits
// - drive bit one open drain, else cmos
// - drive select all bits, four-pin port four; ports C and F have no drive register and read zero
// - data in reads live pin levels
// - data out stored, driven, read back
// - registers reached by bus at window offsets
module cmiop_port
#(
  parameter logic [15:0] STRAP_PATTERN = 16'h0000 // reset-time pattern on the data lines
)
(
  input  wire logic                                  clk,             // 25 MHz clock
  input  wire logic                                  resetn,          // async reset, low
  input  wire logic [cmiop_pkg::AW-1:0]              host_addr,       // window offset
  input  wire logic                                  win_select,      // io window selected
  input  wire logic                                  host_wr,         // register write strobe
  input  wire logic                                  host_rd,         // register read strobe
  input  wire logic [cmiop_pkg::PW-1:0]              host_wdata,      // write data
  output logic      [cmiop_pkg::PW-1:0]              host_rdata,      // read data, registered
  input  wire logic                                  data_port_mode,  // non-multiplexed bus
  input  wire logic [cmiop_pkg::DBW-1:0]             mem_rdata,       // data to drive to host
  input  wire logic                                  mem_rdata_en,    // host read cycle
  output logic      [cmiop_pkg::DBW-1:0]             bus_data_in,     // host data seen on pins
  input  wire logic                                  strap_mode_en,   // reset strap configured
  input  wire logic                                  mcu_reset_active,// host reset asserted
  input  wire logic                                  bus_cycle_active,// host bus cycle running
  input  wire logic                                  periph_select_a, // peripheral select term
  input  wire logic                                  periph_select_b, // peripheral select term
  input  wire logic                                  periph_write,    // host writes peripheral
  output logic      [cmiop_pkg::PW-1:0]              periph_rdata,    // peripheral data in
  input  wire logic                                  isp_active,      // jtag programming
  input  wire logic [cmiop_pkg::JTAG_PINS-1:0]       jtag_pin_o,      // jtag pin values
  input  wire logic [cmiop_pkg::JTAG_PINS-1:0]       jtag_pin_oe,     // jtag pin enables
  output logic      [cmiop_pkg::JTAG_PINS-1:0]       jtag_pin_i,      // jtag pin levels
  input  wire logic [cmiop_pkg::DBW-1:0]             latched_addr,    // latched host address
  input  wire logic [cmiop_pkg::NPORTS-1:0][cmiop_pkg::PW-1:0] oe_term, // logic-array .oe
  input  wire logic [cmiop_pkg::NPORTS-1:0][cmiop_pkg::PW-1:0] pin_i,   // pad levels
  output logic      [cmiop_pkg::NPORTS-1:0][cmiop_pkg::PW-1:0] pin_o,   // pad values
  output logic      [cmiop_pkg::NPORTS-1:0][cmiop_pkg::PW-1:0] pin_oe   // pad enables
);
  import cmiop_pkg::*;

  logic [NPORTS-1:0][PW-1:0] mode_r;
  logic [NPORTS-1:0][PW-1:0] dir_r;
  logic [NPORTS-1:0][PW-1:0] drv_r;
  logic [NPORTS-1:0][PW-1:0] dout_r;
  logic [PW-1:0]             vm_r;
  logic [PW-1:0]             rdata_nxt;
  logic [2:0]                sel_port;
  logic [2:0]                sel_reg;
  logic                      in_window;
  logic                      port_valid;
  logic                      strap_drive;
  logic                      periph_on;
  logic                      periph_sel;

  // implemented bits of a register for a given port
  function automatic logic [PW-1:0] impl_mask(input logic [2:0] port, input logic [2:0] rsel);
    logic [PW-1:0] m;
    m = (port == PORT_D) ? NIBBLE_MASK : FULL_MASK;
    case (rsel)
      REG_MODE:  impl_mask = HAS_MODE[port] ? m : ZERO_MASK;
      REG_DRIVE: impl_mask = HAS_DRIVE[port] ? m : ZERO_MASK;
      default:   impl_mask = m;
    endcase
  endfunction : impl_mask

  assign sel_port   = host_addr[PORT_SEL_LSB +: 3];
  assign sel_reg    = host_addr[REG_SEL_W-1:0];
  assign in_window  = win_select && ((host_addr & ADDR_WIN_MASK) == ZERO_MASK);
  assign port_valid = in_window && (sel_port < 3'(NPORTS)) && (host_addr != ADDR_VM);

  // reset strap wins over all other uses of the upper ports while it holds
  assign strap_drive = strap_mode_en && mcu_reset_active && !bus_cycle_active;
  assign periph_on   = vm_r[VM_PERIPH_BIT];
  assign periph_sel  = periph_select_a | periph_select_b;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mode_r <= '0;
    else if (host_wr && port_valid && sel_reg == REG_MODE)
      mode_r[sel_port] <= host_wdata & impl_mask(sel_port, REG_MODE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dir_r <= '0;
    else if (host_wr && port_valid && sel_reg == REG_DIRECTION)
      dir_r[sel_port] <= host_wdata & impl_mask(sel_port, REG_DIRECTION);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      drv_r <= '0;
    else if (host_wr && port_valid && sel_reg == REG_DRIVE)
      drv_r[sel_port] <= host_wdata & impl_mask(sel_port, REG_DRIVE);
  end

  // data out has no documented reset value; cleared so the pads start quiet
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dout_r <= '0;
    else if (host_wr && port_valid && sel_reg == REG_DATA_OUT)
      dout_r[sel_port] <= host_wdata & impl_mask(sel_port, REG_DATA_OUT);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      vm_r <= CFG_RESET;
    else if (host_wr && in_window && host_addr == ADDR_VM)
      vm_r <= host_wdata;
  end

  always_comb
  begin
    rdata_nxt = ZERO_MASK;
    if (in_window && host_addr == ADDR_VM)
      rdata_nxt = vm_r;
    else if (port_valid)
    begin
      case (sel_reg)
        REG_DATA_IN:   rdata_nxt = pin_i[sel_port] & impl_mask(sel_port, REG_DATA_IN);
        REG_DATA_OUT:  rdata_nxt = dout_r[sel_port];
        REG_DIRECTION: rdata_nxt = dir_r[sel_port];
        REG_DRIVE:     rdata_nxt = drv_r[sel_port];
        REG_MODE:      rdata_nxt = mode_r[sel_port];
        default:       rdata_nxt = ZERO_MASK;
      endcase
    end
  end

  // read data is captured on the strobe and held until the next read
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      host_rdata <= ZERO_MASK;
    else if (host_rd)
      host_rdata <= rdata_nxt;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_data_in <= '0;
    else
      bus_data_in <= {pin_i[PORT_G], pin_i[PORT_F]};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      periph_rdata <= ZERO_MASK;
    else if (periph_on && periph_sel && !periph_write)
      periph_rdata <= pin_i[PORT_F];
  end

  assign jtag_pin_i = pin_i[PORT_E][JTAG_PINS-1:0];

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++)
    begin : g_port
      cmiop_cfg_if cfg ();
      logic [PW-1:0] ovr_en;
      logic [PW-1:0] ovr_val;
      logic [PW-1:0] ovr_oe;

      always_comb
      begin
        ovr_en  = ZERO_MASK;
        ovr_val = ZERO_MASK;
        ovr_oe  = ZERO_MASK;
        if (p == PORT_E && isp_active)
        begin
          // programming never overlaps normal operation, so the pins are simply taken
          ovr_en  = {4'h0, {JTAG_PINS{1'b1}}};
          ovr_val = {4'h0, jtag_pin_o};
          ovr_oe  = {4'h0, jtag_pin_oe};
        end
        else if ((p == PORT_F || p == PORT_G) && strap_drive)
        begin
          ovr_en  = FULL_MASK;
          ovr_val = (p == PORT_F) ? STRAP_PATTERN[PW-1:0] : STRAP_PATTERN[DBW-1:DB_HI_LSB];
          ovr_oe  = FULL_MASK;
        end
        else if ((p == PORT_F || p == PORT_G) && data_port_mode)
        begin
          ovr_en  = FULL_MASK;
          ovr_val = (p == PORT_F) ? mem_rdata[PW-1:0] : mem_rdata[DBW-1:DB_HI_LSB];
          ovr_oe  = mem_rdata_en ? FULL_MASK : ZERO_MASK;
        end
        else if (p == PORT_F && periph_on)
        begin
          ovr_en  = FULL_MASK;
          ovr_val = host_wdata;
          ovr_oe  = (periph_sel && periph_write) ? FULL_MASK : ZERO_MASK;
        end
      end

      assign cfg.mode    = mode_r[p];
      assign cfg.dir     = dir_r[p];
      assign cfg.drive   = drv_r[p];
      assign cfg.dout    = dout_r[p];
      assign cfg.addr    = (p == PORT_G) ? latched_addr[DBW-1:DB_HI_LSB] : latched_addr[PW-1:0];
      assign cfg.oe_term = HAS_OE_TERM[p] ? oe_term[p] : ZERO_MASK;
      assign cfg.mask    = (p == PORT_D) ? NIBBLE_MASK : FULL_MASK;
      assign cfg.ovr_en  = ovr_en;
      assign cfg.ovr_val = ovr_val;
      assign cfg.ovr_oe  = ovr_oe;
      assign pin_o[p]    = cfg.pin_o;
      assign pin_oe[p]   = cfg.pin_oe;

      cmiop_pin_slice u_slice
      (
        .cfg (cfg.slice)
      );
    end
  endgenerate
endmodule : cmiop_port

/* cmiop_port_assertions.sv */
module cmiop_port_assertions
#(
  parameter logic [15:0] STRAP_PATTERN = 16'h0000 // strap value under check
)
(
  input wire logic            clk,              // clock
  input wire logic            resetn,           // async reset, low
  input wire logic [7:0]      host_addr,        // window offset
  input wire logic            win_select,       // window select
  input wire logic            host_wr,          // write strobe
  input wire logic            host_rd,          // read strobe
  input wire logic [7:0]      host_wdata,       // write data
  input wire logic [7:0]      host_rdata,       // read data
  input wire logic            data_port_mode,   // data port mode
  input wire logic [15:0]     mem_rdata,        // data for host
  input wire logic            mem_rdata_en,     // host read cycle
  input wire logic            strap_mode_en,    // strap feature on
  input wire logic            mcu_reset_active, // host in reset
  input wire logic            bus_cycle_active, // host bus cycle
  input wire logic            periph_select_a,  // select term
  input wire logic            periph_select_b,  // select term
  input wire logic            isp_active,       // programming
  input wire logic [3:0]      jtag_pin_o,       // jtag values
  input wire logic [3:0]      jtag_pin_oe,      // jtag enables
  input wire logic [6:0][7:0] oe_term,          // array enables
  input wire logic [6:0][7:0] pin_i,            // pad levels
  input wire logic [6:0][7:0] pin_o,            // pad values
  input wire logic [6:0][7:0] pin_oe            // pad enables
);
  import cmiop_pkg::*;
  logic       strap_on;
  logic       wr_ok;
  logic       vm_r;
  logic [7:0] dir_c_r;
  assign strap_on = strap_mode_en & mcu_reset_active & ~bus_cycle_active;
  assign wr_ok    = host_wr & win_select;
  // shadow copies, so pin checks need no look inside the port
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      vm_r <= 1'b0;
    else if (wr_ok && host_addr == ADDR_VM)
      vm_r <= host_wdata[VM_PERIPH_BIT];
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dir_c_r <= 8'h00;
    else if (wr_ok && host_addr == 8'h12)
      dir_c_r <= host_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_d_upper_float: assert property (pin_oe[PORT_D][7:4] == 4'h0)
    else $error("port d upper pin enabled");
  chk_jtag_takes_pins: assert property (isp_active |-> pin_oe[PORT_E][3:0] == jtag_pin_oe
    && pin_o[PORT_E][3:0] == jtag_pin_o) else $error("jtag pins not handed over");
  chk_strap_drive: assert property (strap_on |-> {pin_o[6], pin_o[5]} == STRAP_PATTERN
    && {pin_oe[6], pin_oe[5]} == 16'hffff) else $error("strap pattern not driven");
  chk_data_port_drive: assert property (!strap_on && data_port_mode && mem_rdata_en
    |-> {pin_o[6], pin_o[5]} == mem_rdata && {pin_oe[6], pin_oe[5]} == 16'hffff)
    else $error("data port not driving");
  chk_periph_float: assert property (vm_r && !strap_on && !data_port_mode
    && !(periph_select_a || periph_select_b) |-> pin_oe[PORT_F] == 8'h00)
    else $error("buffer driven while unselected");
  chk_port_c_oe: assert property (pin_oe[PORT_C] == (dir_c_r | oe_term[PORT_C]))
    else $error("port c enable not direction or term");
  chk_dout_read_back: assert property (wr_ok && host_addr == 8'h01 ##2 host_rd
    && win_select && host_addr == 8'h01 |=> host_rdata == $past(host_wdata, 3))
    else $error("data out read back differs");
  chk_d_dir_read: assert property (host_rd && win_select && host_addr == 8'h1a
    |=> host_rdata[7:4] == 4'h0) else $error("port d upper bits read nonzero");
  chk_bad_reg_read: assert property (host_rd && win_select && host_addr[2:0] > REG_MODE
    |=> host_rdata == 8'h00) else $error("unmapped register read nonzero");
  chk_pin_in_read: assert property (host_rd && win_select && host_addr == 8'h00
    |=> host_rdata == $past(pin_i[PORT_A])) else $error("data in not live pins");
  cover property (wr_ok && host_addr == 8'h01 ##2 host_rd);
  cover property (vm_r && periph_select_a);
  cover property (strap_on ##1 !strap_on);
endmodule : cmiop_port_assertions

bind cmiop_port cmiop_port_assertions #(.STRAP_PATTERN(STRAP_PATTERN)) u_chk (.clk(clk),
  .resetn(resetn), .host_addr(host_addr), .win_select(win_select), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .data_port_mode(data_port_mode), .mem_rdata(mem_rdata), .mem_rdata_en(mem_rdata_en),
  .strap_mode_en(strap_mode_en), .mcu_reset_active(mcu_reset_active),
  .bus_cycle_active(bus_cycle_active), .periph_select_a(periph_select_a),
  .periph_select_b(periph_select_b), .isp_active(isp_active), .jtag_pin_o(jtag_pin_o),
  .jtag_pin_oe(jtag_pin_oe), .oe_term(oe_term), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

/* cmiop_pin_model.sv */
module cmiop_pin_model
(
  input  wire logic            clk,        // clock
  input  wire logic            host_rst,   // host reset, high
  input  wire logic [6:0][7:0] pin_o,      // pad values
  input  wire logic [6:0][7:0] pin_oe,     // pad enables
  input  wire logic [6:0][7:0] ext_val,    // far side values
  input  wire logic [6:0][7:0] ext_en,     // far side enables
  output logic      [6:0][7:0] pin_i,      // resolved levels
  output logic      [15:0]     strap_seen  // bus held at reset release
);
  import cmiop_pkg::*;
  // every pad has a pull-up, so released and open-drain lines read one
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
      for (int b = 0; b < PW; b++)
        pin_i[p][b] = pin_oe[p][b] ? pin_o[p][b] : (ext_en[p][b] ? ext_val[p][b] : 1'b1);
  end
  // last value seen in reset is what the host keeps at release
  always_ff @(posedge clk)
  begin
    if (host_rst)
      strap_seen <= {pin_i[PORT_G], pin_i[PORT_F]};
  end
endmodule : cmiop_pin_model

/* cmiop_port_bench.sv */
module cmiop_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cmiop_pkg::*;
  localparam logic [15:0] STRAP = 16'ha5c3;
  logic clk, resetn, win_select, host_wr, host_rd, data_port_mode, mem_rdata_en, isp_active;
  logic strap_mode_en, mcu_reset_active, bus_cycle_active, periph_write;
  logic periph_select_a, periph_select_b;
  logic [7:0]             host_addr, host_wdata, host_rdata, periph_rdata;
  logic [15:0]            mem_rdata, bus_data_in, latched_addr, strap_seen;
  logic [3:0]             jtag_pin_o, jtag_pin_oe, jtag_pin_i;
  logic [6:0][7:0]        oe_term, pin_i, pin_o, pin_oe, ext_val, ext_en;
  int                     miscompares, compares;
  cmiop_port #(.STRAP_PATTERN(STRAP)) dut (.clk(clk), .resetn(resetn), .host_addr(host_addr),
    .win_select(win_select), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .data_port_mode(data_port_mode), .mem_rdata(mem_rdata),
    .mem_rdata_en(mem_rdata_en), .bus_data_in(bus_data_in), .strap_mode_en(strap_mode_en),
    .mcu_reset_active(mcu_reset_active), .bus_cycle_active(bus_cycle_active),
    .periph_select_a(periph_select_a), .periph_select_b(periph_select_b),
    .periph_write(periph_write), .periph_rdata(periph_rdata), .isp_active(isp_active),
    .jtag_pin_o(jtag_pin_o), .jtag_pin_oe(jtag_pin_oe), .jtag_pin_i(jtag_pin_i),
    .latched_addr(latched_addr), .oe_term(oe_term), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe));
  cmiop_pin_model far (.clk(clk), .host_rst(mcu_reset_active), .pin_o(pin_o), .pin_oe(pin_oe),
    .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i), .strap_seen(strap_seen));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    check(host_rdata, exp);
  endtask : rd
  task automatic results;
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
  initial
  begin
    logic [7:0] e;
    {resetn, host_wr, host_rd, data_port_mode, mem_rdata_en, isp_active, periph_write} = '0;
    {bus_cycle_active, periph_select_a, periph_select_b, jtag_pin_o, jtag_pin_oe} = '0;
    {host_addr, host_wdata, mem_rdata, latched_addr, oe_term, ext_val, ext_en} = '0;
    {win_select, strap_mode_en, mcu_reset_active} = 3'h7;
    miscompares = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    check({pin_o[6], pin_o[5]}, STRAP);
    resetn <= 1'b1;
    for (int p = 0; p < NPORTS; p++)
      for (int r = 2; r < 5; r++)
        rd({2'b00, p[2:0], r[2:0]}, 8'h00);
    bus_cycle_active <= 1'b1;
    @(posedge clk);
    #1;
    check(pin_oe[5], 8'h00);
    @(posedge clk);
    bus_cycle_active <= 1'b0;
    @(posedge clk);
    {mcu_reset_active, data_port_mode, mem_rdata_en, mem_rdata} <= {3'h3, 16'h1e2d};
    @(posedge clk);
    #1;
    check(strap_seen, STRAP);
    check({pin_o[6], pin_o[5]}, 16'h1e2d);
    @(posedge clk);
    mem_rdata_en <= 1'b0;
    {ext_en[6], ext_en[5], ext_val[6], ext_val[5]} <= 32'hffff_8877;
    repeat (2) @(posedge clk);
    #1;
    check(bus_data_in, 16'h8877);
    @(posedge clk);
    {data_port_mode, ext_en[6], ext_en[5]} <= '0;
    for (int p = 0; p < NPORTS; p++)
      for (int r = 2; r < 5; r++)
      begin
        e = (p == 3) ? 8'h0f : 8'hff;
        if ((r == 3 && !HAS_DRIVE[p]) || (r == 4 && !HAS_MODE[p]))
          e = 8'h00;
        wr({2'b00, p[2:0], r[2:0]}, 8'hff);
        rd({2'b00, p[2:0], r[2:0]}, e);
        wr({2'b00, p[2:0], r[2:0]}, 8'h00);
      end
    {ext_en[0], ext_val[0]} <= 16'hf890;
    wr(8'h02, 8'h07);
    wr(8'h01, 8'h5a);
    rd(8'h01, 8'h5a);
    check(pin_oe[0], 8'h07);
    rd(8'h00, 8'h92);
    wr(8'h03, 8'h03);
    check(pin_oe[0], 8'h05);
    oe_term[2] <= 8'h81;
    wr(8'h12, 8'h06);
    check(pin_oe[2], 8'h87);
    latched_addr <= 16'h1234;
    wr(8'h24, 8'h0f);
    wr(8'h22, 8'h0f);
    check(pin_o[4][3:0], 4'h4);
    @(posedge clk);
    {isp_active, jtag_pin_o, jtag_pin_oe} <= 9'h1ac;
    @(posedge clk);
    #1;
    check(pin_oe[4][3:0], 4'hc);
    check(jtag_pin_i, 4'hb);
    @(posedge clk);
    isp_active <= 1'b0;
    wr(8'h38, 8'h80);
    check(pin_oe[5], 8'h00);
    check(pin_o[4][3:0], 4'h4);
    @(posedge clk);
    {periph_select_a, periph_write, host_wdata} <= 10'h33c;
    @(posedge clk);
    #1;
    check({pin_oe[5], pin_o[5]}, 16'hff3c);
    @(posedge clk);
    {periph_select_a, periph_select_b, periph_write} <= 3'h2;
    {ext_en[5], ext_val[5]} <= 16'hff96;
    repeat (2) @(posedge clk);
    #1;
    check(periph_rdata, 8'h96);
    @(posedge clk);
    {periph_select_b, ext_en[5]} <= '0;
    rd(8'h07, 8'h00);
    wr(8'h42, 8'hff);
    rd(8'h02, 8'h07);
    results();
  end
endmodule : cmiop_port_bench
